// *** dv/rsc_combiner_test.sv ***
// self-checking bench for the reset source combiner
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, g, e); end end
module rsc_combiner_test;
    import rsc_pkg::*;
    localparam int TR = 8; // short stretch keeps the run small
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        fuse    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [3:0]  paddr   = 4'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sys_rst;
    logic [15:0] cause;
    logic        wd_en;
    logic        irq;
    logic        vreg;
    logic        bor, pin, instr, wdt, trap, iop, slp, idl;
    int          errors     = 0;
    int          n_compared = 0;

    always #25 clk_sys = ~clk_sys;

    rsc_src_model rsc_src_model_inst (.i_clk_sys(clk_sys), .o_bor(bor), .o_pin(pin), .o_instr(instr),
        .o_wdt(wdt), .o_trap(trap), .o_iop(iop), .o_sleep(slp), .o_idle(idl));

    rsc_combiner #(.TRST_CYCLES(TR)) rsc_combiner_inst (.i_clk_sys(clk_sys), .i_rst(rst),
        .i_brown_out_reset(bor), .i_external_pin_reset(pin), .i_reset_instr(instr),
        .i_watchdog_timeout(wdt), .i_trap_conflict(trap), .i_illegal_op(iop), .i_power_save_instruction_sleep(slp),
        .i_power_save_instruction_idle(idl), .i_fuse_watchdog_enable(fuse), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_system_reset_out(sys_rst), .o_reset_cause(cause),
        .o_watchdog_enable(wd_en), .o_regulator_sleep_standby(vreg), .o_irq(irq));

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // sample pready at each rising edge; the answer is taken at that same edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x, "read data")
        `CHK(e, xe, "read error flag")
    endtask

    // wait for reset out to rise, then count its high cycles, both bounded
    task automatic wait_rel(output int cnt);
        int n;
        n = 0;
        cnt = 0;
        @(negedge clk_sys);
        while (sys_rst !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        while (sys_rst === 1'b1 && cnt < 2000) begin
            @(negedge clk_sys);
            cnt++;
        end
        if (n == 20 || cnt == 2000) errors++;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, errors);
    endtask

    task automatic t_por;
        int c;
        wait_rel(c);
        `CHK((c >= TR && c <= TR + 3), 1'b1, "power-on stretch")
        rdchk(RSC_OFF_CAUSE, 32'h0000_0003, 1'b0);
        wr(RSC_OFF_SCRATCH, 32'hA5C3_0F1E);
        done("power_on");
    endtask

    // each synchronous source: stretch length and its own flag
    task automatic t_sync;
        int k[4] = '{2, 3, 4, 5};
        int b[4] = '{6, 4, 15, 14};
        int c;
        for (int i = 0; i < 4; i++) begin
            wr(RSC_OFF_CAUSE, 32'h0);
            rsc_src_model_inst.fire(k[i], 1);
            wait_rel(c);
            `CHK(c, TR + 1, "reset stretch")
            rdchk(RSC_OFF_CAUSE, 32'h1 << b[i], 1'b0);
        end
        rdchk(RSC_OFF_SCRATCH, 32'hA5C3_0F1E, 1'b0);
        done("sync_sources");
    endtask

    // pin and brown-out pass the synchroniser; brown-out wipes its flag set, keeps pin flag
    task automatic t_async;
        int c;
        wr(RSC_OFF_CAUSE, 32'h0);
        rsc_src_model_inst.fire(1, 3);
        wait_rel(c);
        `CHK((c >= TR + 1), 1'b1, "pin reset stretch")
        rdchk(RSC_OFF_CAUSE, 32'h0000_0080, 1'b0);
        wr(RSC_OFF_CAUSE, 32'h0000_C1FD);
        rsc_src_model_inst.fire(0, 3);
        wait_rel(c);
        rdchk(RSC_OFF_CAUSE, 32'h0000_01A3, 1'b0);
        `CHK(vreg, 1'b1, "regulator standby bit")
        done("async_sources");
    endtask

    // software writes only store, never reset; unmapped place refused
    task automatic t_sw;
        wr(RSC_OFF_CAUSE, 32'h0000_FFFF);
        repeat (4) @(negedge clk_sys);
        `CHK(sys_rst, 1'b0, "no reset from write")
        rdchk(RSC_OFF_CAUSE, 32'h0000_C1FF, 1'b0);
        rdchk(4'h2, 32'h0, 1'b1);
        done("software_write");
    endtask

    task automatic t_power_save_instruction;
        wr(RSC_OFF_CAUSE, 32'h0000_0010);
        rsc_src_model_inst.fire(6, 1);
        rdchk(RSC_OFF_CAUSE, 32'h0000_0008, 1'b0);
        rsc_src_model_inst.fire(7, 1);
        rdchk(RSC_OFF_CAUSE, 32'h0000_000C, 1'b0);
        done("power_save");
    endtask

    task automatic t_wde;
        wr(RSC_OFF_CAUSE, 32'h0000_0020);
        repeat (2) @(negedge clk_sys);
        `CHK(wd_en, 1'b1, "soft enable on")
        wr(RSC_OFF_CAUSE, 32'h0);
        repeat (2) @(negedge clk_sys);
        `CHK(wd_en, 1'b0, "soft enable off")
        @(posedge clk_sys);
        fuse <= 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(wd_en, 1'b1, "fuse forces enable")
        @(posedge clk_sys);
        fuse <= 1'b0;
        done("watchdog_enable");
    endtask

    // raise, mask, clear the interrupt; mask returns to zero through a reset
    task automatic t_irq;
        int c;
        wr(RSC_OFF_IRQ_MASK, 32'h0);
        wr(RSC_OFF_IRQ_STAT, 32'h7);
        rsc_src_model_inst.fire(3, 1);
        wait_rel(c);
        rdchk(RSC_OFF_IRQ_STAT, 32'h5, 1'b0);
        `CHK(irq, 1'b0, "masked interrupt")
        wr(RSC_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(negedge clk_sys);
        `CHK(irq, 1'b1, "interrupt raised")
        wr(RSC_OFF_IRQ_STAT, 32'h4);
        repeat (2) @(negedge clk_sys);
        `CHK(irq, 1'b0, "interrupt cleared")
        wr(RSC_OFF_IRQ_MASK, 32'h7);
        rsc_src_model_inst.fire(2, 1);
        wait_rel(c);
        rdchk(RSC_OFF_IRQ_MASK, 32'h0, 1'b0);
        done("interrupt");
    endtask

    // second power-on in mid-run clears all flags but power-on and brown-out
    task automatic t_por2;
        int c;
        wr(RSC_OFF_CAUSE, 32'h0000_C1FC);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        wait_rel(c);
        rdchk(RSC_OFF_CAUSE, 32'h0000_0003, 1'b0);
        done("second_power_on");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // main sequence after an 8 cycle reset
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_por();
        t_sync();
        t_async();
        t_sw();
        t_power_save_instruction();
        t_wde();
        t_irq();
        t_por2();
        report_and_stop();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        errors++;
        report_and_stop();
    end
endmodule // rsc_combiner_test
`default_nettype wire

// *** dv/rsc_src_model.sv ***
// reset source model: supply monitors, pin, watchdog, cpu traps and power-save
`timescale 1ns/1ns
`default_nettype none
module rsc_src_model (
    input  wire logic i_clk_sys,
    output logic      o_bor,
    output logic      o_pin,
    output logic      o_instr,
    output logic      o_wdt,
    output logic      o_trap,
    output logic      o_iop,
    output logic      o_sleep,
    output logic      o_idle
);
    logic [7:0] lines;

    // one bit per source line, all idle low
    assign {o_idle, o_sleep, o_iop, o_trap, o_wdt, o_instr, o_pin, o_bor} = lines;
    initial lines = 8'h00;

    // raise one source for len cycles; async monitors take two cycles to pass the synchroniser
    task automatic fire(input int k, input int len);
        @(posedge i_clk_sys);
        lines[k] <= 1'b1;
        repeat (len) @(posedge i_clk_sys);
        lines[k] <= 1'b0;
    endtask
endmodule // rsc_src_model
`default_nettype wire

// *** hdl/rsc_combiner.sv ***
// reset source combiner with cause status register behind apb
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module rsc_combiner
    import rsc_pkg::*;
#(
    parameter int TRST_CYCLES = RSC_TRST_CYC
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    input  wire logic                          i_brown_out_reset,
    input  wire logic                          i_external_pin_reset,
    input  wire logic                          i_reset_instr,
    input  wire logic                          i_watchdog_timeout,
    input  wire logic                          i_trap_conflict,
    input  wire logic                          i_illegal_op,
    input  wire logic                          i_power_save_instruction_sleep,
    input  wire logic                          i_power_save_instruction_idle,
    input  wire logic                          i_fuse_watchdog_enable,
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [rsc_pkg::RSC_ADDR_W-1:0] i_paddr,
    input  wire logic [rsc_pkg::RSC_DATA_W-1:0] i_pwdata,
    output logic      [rsc_pkg::RSC_DATA_W-1:0] o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    output logic                               o_system_reset_out,
    output logic      [15:0]                   o_reset_cause,
    output logic                               o_watchdog_enable,
    output logic                               o_regulator_sleep_standby,
    output logic                               o_irq
);
    import rsc_pkg::*;

    typedef struct packed {
        rsc_state_t                state;
        logic [15:0]               cause;
        logic [RSC_IRQ_W-1:0]      irq_stat;
        logic [RSC_IRQ_W-1:0]      irq_mask;
        logic [RSC_DATA_W-1:0]     scratch;
        logic [RSC_DATA_W-1:0]     prdata;
        logic                      pready;
        logic                      pslverr;
        logic                      irq;
        logic                      sys_rst;
        logic                      wdt_en;
    } rsc_top_st_t;

    rsc_top_st_t          st;
    rsc_top_st_t          next_st;
    logic [1:0]           async_sync;
    logic                 src_brown;
    logic                 src_pin;
    logic                 src_active;
    logic                 acc;
    logic                 wr_now;
    logic [RSC_IRQ_W-1:0] ev;
    logic [15:0]          cause_v;

    rsc_stretch_if stretch ();

    // address match used by decode, write strobes and read mux
    function automatic logic rsc_is(input logic [RSC_ADDR_W-1:0] a,
                                    input logic [RSC_ADDR_W-1:0] off);
        return a == off;
    endfunction

    function automatic logic rsc_mapped(input logic [RSC_ADDR_W-1:0] a);
        return rsc_is(a, RSC_OFF_CAUSE) || rsc_is(a, RSC_OFF_IRQ_STAT) ||
               rsc_is(a, RSC_OFF_IRQ_MASK) || rsc_is(a, RSC_OFF_SCRATCH);
    endfunction

    // brown-out and pin are asynchronous levels
    rsc_sync #(
        .W (2)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_external_pin_reset, i_brown_out_reset}),
        .o_sync    (async_sync)
    );

    rsc_stretch #(
        .CYCLES (TRST_CYCLES)
    ) u_stretch (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .tmr       (stretch.timer)
    );

    // combine every source; power-on arrives as i_rst itself
    assign src_brown  = async_sync[0];
    assign src_pin    = async_sync[1];
    assign src_active = src_brown | src_pin | i_reset_instr | i_watchdog_timeout |
                        i_trap_conflict | i_illegal_op;
    assign stretch.restart = src_active;

    // bus write lands on the edge where pready is seen high
    assign acc    = i_psel & i_penable;
    assign wr_now = acc & st.pready & i_pwrite;

    // interrupt events
    assign ev[RSC_I_RELEASE] = st.sys_rst & ~(src_active | stretch.busy);
    assign ev[RSC_I_POWER_SAVE_INSTRUCTION]  = i_power_save_instruction_sleep | i_power_save_instruction_idle;
    assign ev[RSC_I_WDT]     = i_watchdog_timeout;

    // cause flags: software first, then hardware clears, then hardware sets
    always_comb begin
        cause_v = st.cause;
        if (wr_now && rsc_is(i_paddr, RSC_OFF_CAUSE)) begin
            cause_v = i_pwdata[15:0] & RSC_CAUSE_WMASK;
        end
        if (src_brown) begin
            cause_v = cause_v & ~RSC_CAUSE_BOR_CLR;
        end
        if (i_power_save_instruction_sleep || i_power_save_instruction_idle) begin
            cause_v[RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        // sets come last so an event beats a same-cycle clear
        if (src_brown) begin
            cause_v[RSC_B_BOR] = 1'b1;
        end
        if (src_pin) begin
            cause_v[RSC_B_PIN_RESET_FLAG] = 1'b1;
        end
        if (i_reset_instr) begin
            cause_v[RSC_B_SWR] = 1'b1;
        end
        if (i_watchdog_timeout) begin
            cause_v[RSC_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        end
        if (i_trap_conflict) begin
            cause_v[RSC_B_TRAP] = 1'b1;
        end
        if (i_illegal_op) begin
            cause_v[RSC_B_IOP] = 1'b1;
        end
        if (i_power_save_instruction_sleep) begin
            cause_v[RSC_B_SLEEP] = 1'b1;
        end
        if (i_power_save_instruction_idle) begin
            cause_v[RSC_B_IDLE] = 1'b1;
        end
    end

    // next state of the whole block
    always_comb begin
        next_st = st;
        // hold until sources drop and the stretch runs out
        next_st.state   = (src_active || stretch.busy) ? RSC_ST_HOLD : RSC_ST_RUN;
        next_st.sys_rst = (next_st.state == RSC_ST_HOLD);
        next_st.cause   = cause_v;

        // sticky interrupt status, write one to clear, set wins
        if (wr_now && rsc_is(i_paddr, RSC_OFF_IRQ_STAT)) begin
            next_st.irq_stat = st.irq_stat & ~i_pwdata[RSC_IRQ_W-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | ev;
        if (wr_now && rsc_is(i_paddr, RSC_OFF_IRQ_MASK)) begin
            next_st.irq_mask = i_pwdata[RSC_IRQ_W-1:0];
        end
        // the interrupt mask is pinned to its reset value while the system is held
        if (st.sys_rst) begin
            next_st.irq_mask = RSC_IRQ_MASK_RST;
        end
        // scratch has no reset value and rides through every reset
        if (wr_now && rsc_is(i_paddr, RSC_OFF_SCRATCH)) begin
            next_st.scratch = i_pwdata;
        end
        next_st.irq    = |(next_st.irq_stat & next_st.irq_mask);
        next_st.wdt_en = i_fuse_watchdog_enable | next_st.cause[RSC_B_SOFT_WATCHDOG_ENABLE];

        // apb: one wait state, answer on second access cycle
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (acc && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !rsc_mapped(i_paddr);
            next_st.prdata  = '0;
            unique case (1'b1)
                rsc_is(i_paddr, RSC_OFF_CAUSE):    next_st.prdata[15:0] = st.cause;
                rsc_is(i_paddr, RSC_OFF_IRQ_STAT): next_st.prdata[RSC_IRQ_W-1:0] = st.irq_stat;
                rsc_is(i_paddr, RSC_OFF_IRQ_MASK): next_st.prdata[RSC_IRQ_W-1:0] = st.irq_mask;
                rsc_is(i_paddr, RSC_OFF_SCRATCH):  next_st.prdata = st.scratch;
                default:                           next_st.prdata = '0;
            endcase
        end

        // power-on: the root reset, scratch deliberately untouched
        if (i_rst) begin
            next_st.state    = RSC_ST_HOLD;
            next_st.sys_rst  = 1'b1;
            next_st.cause    = RSC_CAUSE_POR_VAL;
            next_st.irq_stat = RSC_IRQ_STAT_RST;
            next_st.irq_mask = RSC_IRQ_MASK_RST;
            next_st.prdata   = '0;
            next_st.pready   = 1'b0;
            next_st.pslverr  = 1'b0;
            next_st.irq      = 1'b0;
            next_st.wdt_en   = i_fuse_watchdog_enable;
        end
    end

    // release only on a clock edge
    always_ff @(posedge i_clk_sys) begin
        st <= next_st;
    end

    // all outputs straight from the state register
    assign o_prdata                  = st.prdata;
    assign o_pready                  = st.pready;
    assign o_pslverr                 = st.pslverr;
    assign o_system_reset_out        = st.sys_rst;
    assign o_reset_cause             = st.cause;
    assign o_watchdog_enable         = st.wdt_en;
    assign o_regulator_sleep_standby = st.cause[RSC_B_REGULATOR_SLEEP_STANDBY];
    assign o_irq                     = st.irq;

    // checks
    int unsigned hi_len;
    always_ff @(posedge i_clk_sys) begin
        hi_len <= (i_rst || !st.sys_rst) ? 0 : hi_len + 1;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    chk_src_asserts_rst: assert property (src_active |=> o_system_reset_out)
        else $error("reset source did not assert system reset");
    chk_pin_flag_set: assert property (src_pin |=> o_reset_cause[RSC_B_PIN_RESET_FLAG])
        else $error("pin reset flag not set");
    chk_por_value: assert property ($fell(i_rst) |-> o_reset_cause[1:0] == 2'b11 &&
                                     o_reset_cause[15:2] == '0 && o_system_reset_out)
        else $error("wrong cause value after power-on");
    chk_trap_sticky: assert property (o_reset_cause[RSC_B_TRAP] && !src_brown &&
                                      !(wr_now && rsc_is(i_paddr, RSC_OFF_CAUSE)) |=> o_reset_cause[RSC_B_TRAP])
        else $error("trap flag lost without clearing event");
    chk_wdt_clear: assert property ((i_power_save_instruction_sleep || i_power_save_instruction_idle) && !i_watchdog_timeout
                                    |=> !o_reset_cause[RSC_B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag survived power-save");
    chk_sleep_set: assert property (i_power_save_instruction_sleep |=> o_reset_cause[RSC_B_SLEEP])
        else $error("sleep flag not set");
    chk_fuse_wdt: assert property (i_fuse_watchdog_enable |=> o_watchdog_enable)
        else $error("fuse did not force watchdog on");
    chk_hold_time: assert property ($fell(o_system_reset_out) |-> hi_len >= TRST_CYCLES)
        else $error("system reset released too early");
    chk_hold_after: assert property ($fell(src_active) |-> o_system_reset_out[*8])
        else $error("system reset dropped right after source");
    chk_hw_wins: assert property (i_reset_instr && wr_now && rsc_is(i_paddr, RSC_OFF_CAUSE)
                                  |=> o_reset_cause[RSC_B_SWR])
        else $error("software write beat hardware set");
    chk_mask_forced: assert property (st.sys_rst |=> st.irq_mask == RSC_IRQ_MASK_RST)
        else $error("mask not forced during system reset");
    chk_sw_no_reset: assert property (!o_system_reset_out && !src_active && !stretch.busy
                                      |=> !o_system_reset_out)
        else $error("system reset without a source");

    cov_wdt_reset: cover property (i_watchdog_timeout ##1 o_system_reset_out [*2] ##[1:1000] !o_system_reset_out);
    cov_bor_reset: cover property (src_brown ##1 o_reset_cause[RSC_B_BOR]);
    cov_irq_raise: cover property ($rose(o_irq));
    cov_bus_err:   cover property (o_pready && o_pslverr);
endmodule // rsc_combiner
`default_nettype wire

// *** hdl/rsc_pkg.sv ***
// package of constants and types for the reset source combiner
package rsc_pkg;
    // register bus geometry
    localparam int          RSC_ADDR_W         = 4;
    localparam int          RSC_DATA_W         = 32;
    localparam logic [3:0]  RSC_OFF_CAUSE      = 4'h0;
    localparam logic [3:0]  RSC_OFF_IRQ_STAT   = 4'h4;
    localparam logic [3:0]  RSC_OFF_IRQ_MASK   = 4'h8;
    localparam logic [3:0]  RSC_OFF_SCRATCH    = 4'hC;

    // reset cause status bit positions
    localparam int          RSC_B_POR          = 0;
    localparam int          RSC_B_BOR          = 1;
    localparam int          RSC_B_IDLE         = 2;
    localparam int          RSC_B_SLEEP        = 3;
    localparam int          RSC_B_WATCHDOG_TIMEOUT_FLAG         = 4;
    localparam int          RSC_B_SOFT_WATCHDOG_ENABLE       = 5;
    localparam int          RSC_B_SWR          = 6;
    localparam int          RSC_B_PIN_RESET_FLAG         = 7;
    localparam int          RSC_B_REGULATOR_SLEEP_STANDBY        = 8;
    localparam int          RSC_B_IOP          = 14;
    localparam int          RSC_B_TRAP         = 15;
    localparam logic [15:0] RSC_CAUSE_POR_VAL  = 16'h0003;
    localparam logic [15:0] RSC_CAUSE_WMASK    = 16'hC1FF;
    // flags that a brown-out wipes: trap, illegal op, instruction, watchdog, sleep, idle
    localparam logic [15:0] RSC_CAUSE_BOR_CLR  = 16'hC05C;

    // interrupt status and mask layout
    localparam int          RSC_IRQ_W          = 3;
    localparam int          RSC_I_RELEASE      = 0;
    localparam int          RSC_I_POWER_SAVE_INSTRUCTION       = 1;
    localparam int          RSC_I_WDT          = 2;
    localparam logic [2:0]  RSC_IRQ_MASK_RST   = 3'h0;
    localparam logic [2:0]  RSC_IRQ_STAT_RST   = 3'h0;

    // internal state reset time
    localparam int          RSC_CLK_MHZ        = 20;
    localparam int          RSC_TRST_US        = 20;
    localparam int          RSC_TRST_CYC       = RSC_TRST_US * RSC_CLK_MHZ;
    localparam int          RSC_CNT_W          = 16;

    // sequencer states
    typedef enum logic [1:0] {
        RSC_ST_HOLD = 2'b01,
        RSC_ST_RUN  = 2'b10
    } rsc_state_t;
endpackage

// *** hdl/rsc_stretch.sv ***
// reset stretch timer: holds busy for the internal reset time
`timescale 1ns/1ns
`default_nettype none
module rsc_stretch
    import rsc_pkg::*;
#(
    parameter int CYCLES = RSC_TRST_CYC
) (
    input  wire logic    i_clk_sys,
    input  wire logic    i_rst,
    rsc_stretch_if.timer tmr
);
    typedef struct packed {
        logic [RSC_CNT_W-1:0] cnt;
    } rsc_tmr_st_t;

    localparam logic [RSC_CNT_W-1:0] LOAD = RSC_CNT_W'(CYCLES);

    rsc_tmr_st_t st;
    rsc_tmr_st_t next_st;

    // reload while any source is live, then count down to zero
    always_comb begin
        next_st = st;
        if (i_rst || tmr.restart) begin
            next_st.cnt = LOAD;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - RSC_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st <= next_st;
    end

    assign tmr.busy = (st.cnt != '0);
endmodule // rsc_stretch
`default_nettype wire

// *** hdl/rsc_stretch_if.sv ***
// link between the combiner and its reset stretch timer
`timescale 1ns/1ns
`default_nettype none
interface rsc_stretch_if;
    logic restart;
    logic busy;
    modport timer (input restart, output busy);
    modport ctrl  (output restart, input busy);
endinterface
`default_nettype wire

// *** hdl/rsc_sync.sv ***
// two-flop synchroniser for asynchronous reset source levels
`timescale 1ns/1ns
`default_nettype none
module rsc_sync #(
    parameter int W = 2
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rsc_sync_st_t;

    rsc_sync_st_t st;
    rsc_sync_st_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.meta   = i_async;
        next_st.stable = st.meta;
        if (i_rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st <= next_st;
    end

    assign o_sync = st.stable;
endmodule // rsc_sync
`default_nettype wire
